// [hw/tsm_monitor.sv]
// Fault supervision core with APB register access
//
// Summary of operation
// - Channel 1-18 reds, red enable and inhibits come in on the red cable.
// - Missing red interface cable latches a fault and flashes the cabinet.
// - Inhibit inputs, qualified over 550 ms, block only red failure checks.
// - Red input counts on after 500 ms above threshold, off at once.
// - Green and yellow inputs count on after 500 ms, off at once.
// - Faults other than settings stay latched until front panel or remote reset.
// - Dark channel faults after 850 or 1350 ms, by controller type.
// - Red failure check is enabled per channel.
// - Red failure check needs red enable, no inhibit, relay common inactive.
// - Yellow after green must last 2.7 s or a clearance fault latches.
// - Clearance check per channel, off for yellow inhibit or gating.
// - Two indications on together over 350 ms latch a dual fault.
// - Three-colour dual per channel, green-yellow dual global, both gated.
// - Live settings are compared with the stored copy; mismatch latches.
// - Settings fault clears only by 3 s front reset hold.
// - AC drop flashes the cabinet, power lamp blinks 2 Hz, then steady.
// - Latched faults survive an AC interruption.
// - Flash interval after power-up or restore, lamp at 4 Hz.
// - Interval ends after 6 s, five watchdog edges and AC restored.
// - Fewer than five watchdog edges by 10 s latches a watchdog fault.
// - Arrow mode switch plus per-phase arrow selects.
// - Standard arrow mode pairs channels 9-12 with greens 1, 3, 5, 7.
// - Polarity bit inverts the relay common sense.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module tsm_monitor #(
  parameter int TICK_CYCLES = tsm_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [tsm_pkg::NCH-1:0] field_red,
  input wire logic [tsm_pkg::NCH-1:0] field_yel,
  input wire logic [tsm_pkg::NCH-1:0] field_grn,
  input wire logic red_enable,
  input wire logic [1:0] sf_inhibit,
  input wire logic relay_common_sense,
  input wire logic red_interface_cable,
  input wire logic watchdog_in,
  input wire logic ac_above_dropout,
  input wire logic ac_above_restore,
  input wire logic front_reset,
  input wire logic remote_reset,
  output logic cabinet_flash,
  output logic ac_led,
  output logic prog_led
);
  import tsm_pkg::*;

  localparam int CFG_W = CTRL_W + 4 * NCH;

  typedef struct packed {
    tsm_state_e st;
    logic [NIN-1:0] m1;
    logic [NIN-1:0] m2;
    logic wd_d;
    logic fr_d;
    logic rm_d;
    logic [TW-1:0] fl_ms;
    logic [TW-1:0] blink_ms;
    logic [TW-1:0] hold_ms;
    logic [2:0] wd_cnt;
    logic b4;
    logic b2;
    logic [CTRL_W-1:0] ctrl;
    logic [NCH-1:0] rf_en;
    logic [NCH-1:0] cl_en;
    logic [NCH-1:0] du_en;
    logic [NCH-1:0] yinh;
    logic [NCH-1:0] armed;
    logic [NCH-1:0] fch;
    logic [CFG_W-1:0] cfg_sv;
    logic cfg_ok;
    logic [NCH-1:0][TW-1:0] rf_t;
    logic [NCH-1:0][TW-1:0] du_t;
    logic [NCH-1:0][TW-1:0] cl_t;
    logic [3:0][TW-1:0] fr_t;
    logic f_red;
    logic f_clr;
    logic f_dual;
    logic f_cfg;
    logic f_wdog;
    logic f_cable;
    logic f_rate;
    logic cab_flash;
    logic ac_led;
    logic prog_led;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tsm_top_s;

  tsm_top_s s, next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [TW-1:0] inc(input logic [TW-1:0] v);
    return (v == '1) ? v : v + 14'h0001;
  endfunction

  function automatic logic multi(input logic [3:0] v);
    return (v & (v - 4'h1)) != 4'h0;
  endfunction

  // ----------------------------------------------------------------
  // Tick and qualifiers
  // ----------------------------------------------------------------
  logic tk;
  logic [3*NCH-1:0] q_rgy;
  logic [1:0] q_sf;

  tsm_tick #(.CYC(TICK_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tk)
  );

  tsm_qual #(.W(3 * NCH), .ON_MS(FIELD_ON_MS)) u_qfield (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tk),
    .raw(s.m2[I_REN-1:I_RED]),
    .q(q_rgy)
  );

  tsm_qual #(.W(2), .ON_MS(SF_ON_MS)) u_qsf (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tk),
    .raw(s.m2[I_RCS-1:I_SF]),
    .q(q_sf)
  );

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  logic [NCH-1:0] qr, qy, qg;
  logic ren, rcs_act, mon, red_ok, gate, clr, wdx, any_f;
  logic [CFG_W-1:0] cfg;
  logic [STAT_W-1:0] stat;
  logic [TW-1:0] rf_lim;

  always_comb begin
    qr = q_rgy[NCH-1:0];
    qy = q_rgy[2*NCH-1:NCH];
    qg = q_rgy[3*NCH-1:2*NCH];
    ren = s.m2[I_REN];
    rcs_act = s.m2[I_RCS] ^ s.ctrl[C_FAILSAFE];
    mon = s.st == ST_RUN;
    red_ok = ren & ~|q_sf & ~rcs_act;
    gate = ren & ~rcs_act;
    clr = (s.m2[I_FRONT] & ~s.fr_d) | (s.m2[I_REMOTE] & ~s.rm_d);
    wdx = (s.m2[I_WD] ^ s.wd_d) & (s.fl_ms != '0);
    any_f = s.f_red | s.f_clr | s.f_dual | s.f_cfg | s.f_wdog | s.f_cable | s.f_rate;
    cfg = {s.ctrl, s.rf_en, s.cl_en, s.du_en, s.yinh};
    rf_lim = s.ctrl[C_TYPE2] ? RF2_MS : RF1_MS;
    stat = '0;
    stat[S_ANY] = any_f;
    stat[S_RED] = s.f_red;
    stat[S_CLR] = s.f_clr;
    stat[S_DUAL] = s.f_dual;
    stat[S_CFG] = s.f_cfg;
    stat[S_WDOG] = s.f_wdog;
    stat[S_CABLE] = s.f_cable;
    stat[S_ACDROP] = s.st == ST_DROP;
    stat[S_RATE] = s.f_rate;
    stat[S_FLASH] = s.st == ST_FLASH;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic r, y, g, ga, cond, arw;
    logic [3:0] on;
    r = 1'h0;
    y = 1'h0;
    g = 1'h0;
    ga = 1'h0;
    cond = 1'h0;
    arw = 1'h0;
    on = 4'h0;
    next_s = s;
    // Red cable pins, inhibits and relay common sense share one sync path
    next_s.m1 = {relay_common_sense, sf_inhibit, red_enable, field_grn, field_yel, field_red,
                 remote_reset, front_reset, ac_above_restore, ac_above_dropout, watchdog_in,
                 red_interface_cable};
    next_s.m2 = s.m1;
    next_s.wd_d = s.m2[I_WD];
    next_s.fr_d = s.m2[I_FRONT];
    next_s.rm_d = s.m2[I_REMOTE];

    // Clears first, so a fault raised below in this cycle still lands
    if (clr) begin
      next_s.f_red = 1'h0;
      next_s.f_clr = 1'h0;
      next_s.f_dual = 1'h0;
      next_s.f_wdog = 1'h0;
      next_s.f_cable = 1'h0;
      next_s.f_rate = 1'h0;
      next_s.fch = '0;
    end
    if (s.m2[I_FRONT] && tk) begin
      next_s.hold_ms = inc(s.hold_ms);
    end else if (!s.m2[I_FRONT]) begin
      next_s.hold_ms = '0;
    end
    if (s.hold_ms >= CFG_HOLD_MS) begin
      next_s.f_cfg = 1'h0;
      next_s.cfg_sv = cfg;
    end

    // Per-channel checks
    for (int i = 0; i < NCH; i++) begin
      r = qr[i];
      y = qy[i];
      g = qg[i];
      ga = 1'h0;
      if (i >= 8 && i < 12 && s.ctrl[C_PHASE + i - 8] && !s.ctrl[C_COMPACT]) begin
        ga = qg[2 * (i - 8)];
      end
      on = {r, y, g, ga};

      cond = mon & red_ok & s.rf_en[i] & (on == 4'h0);
      next_s.rf_t[i] = cond ? (tk ? inc(s.rf_t[i]) : s.rf_t[i]) : '0;
      if (cond && s.rf_t[i] >= rf_lim) begin
        next_s.f_red = 1'h1;
        next_s.fch[i] = 1'h1;
      end

      cond = mon & gate & ((s.du_en[i] & multi(on)) | (s.ctrl[C_GYDUAL] & y & (g | ga)));
      next_s.du_t[i] = cond ? (tk ? inc(s.du_t[i]) : s.du_t[i]) : '0;
      if (cond && s.du_t[i] >= DUAL_MS) begin
        next_s.f_dual = 1'h1;
        next_s.fch[i] = 1'h1;
      end

      // Yellow is timed on the raw level; qualified red closes the window
      if (g | ga) begin
        next_s.armed[i] = 1'h1;
        next_s.cl_t[i] = '0;
      end else if (s.armed[i]) begin
        if (s.m2[I_YEL + i] && tk) begin
          next_s.cl_t[i] = inc(s.cl_t[i]);
        end
        if (r) begin
          next_s.armed[i] = 1'h0;
          if (mon && gate && s.cl_en[i] && !s.yinh[i] && s.cl_t[i] < CLR_MS) begin
            next_s.f_clr = 1'h1;
            next_s.fch[i] = 1'h1;
          end
        end
      end
    end

    // Flashing arrow rate: steady arrow too long means no flashing
    for (int p = 0; p < 4; p++) begin
      arw = s.m2[I_GRN + 8 + p] & s.ctrl[C_PHASE + p] & ~s.ctrl[C_COMPACT] & ~s.ctrl[C_RATEDIS];
      next_s.fr_t[p] = (mon && arw) ? (tk ? inc(s.fr_t[p]) : s.fr_t[p]) : '0;
      if (mon && arw && s.fr_t[p] >= RATE_MS) begin
        next_s.f_rate = 1'h1;
        next_s.fch[8 + p] = 1'h1;
      end
    end

    if (mon && !s.m2[I_CABLE]) begin
      next_s.f_cable = 1'h1;
    end

    // Settings snapshot and live comparison
    if (mon && !s.cfg_ok) begin
      next_s.cfg_sv = cfg;
      next_s.cfg_ok = 1'h1;
    end
    if (s.cfg_ok && cfg != s.cfg_sv) begin
      next_s.f_cfg = 1'h1;
    end

    // Power sequencing; no fault is cleared here so they ride out a drop
    unique case (s.st)
      ST_FLASH: begin
        if (tk) begin
          next_s.fl_ms = inc(s.fl_ms);
        end
        if (wdx && s.wd_cnt != WD_TRANS) begin
          next_s.wd_cnt = s.wd_cnt + 3'h1;
        end
        if (!s.m2[I_ACOK]) begin
          next_s.st = ST_DROP;
        end else if (s.fl_ms >= FLASH_MIN_MS && s.wd_cnt == WD_TRANS && s.m2[I_ACRS]) begin
          next_s.st = ST_RUN;
        end
        if (s.fl_ms == WD_LIMIT_MS && s.wd_cnt != WD_TRANS) begin
          next_s.f_wdog = 1'h1;
        end
      end
      ST_RUN: begin
        if (!s.m2[I_ACOK]) begin
          next_s.st = ST_DROP;
        end
      end
      ST_DROP: begin
        if (s.m2[I_ACRS]) begin
          next_s.st = ST_FLASH;
          next_s.fl_ms = '0;
          next_s.wd_cnt = 3'h0;
        end
      end
      default: begin
        next_s.st = ST_FLASH;
      end
    endcase

    // Indicator blink phases, 4 Hz and 2 Hz at half duty
    if (tk) begin
      if (s.blink_ms >= BLINK_MS - 14'h0001) begin
        next_s.blink_ms = '0;
        next_s.b4 = ~s.b4;
        next_s.b2 = s.b2 ^ s.b4;
      end else begin
        next_s.blink_ms = s.blink_ms + 14'h0001;
      end
    end
    next_s.cab_flash = (s.st != ST_RUN) | any_f;
    next_s.ac_led = (s.st == ST_RUN) | (s.st == ST_FLASH & s.b4) | (s.st == ST_DROP & s.b2);
    next_s.prog_led = s.f_cfg & s.b2;

    // APB slave, zero wait states; data is fetched in the setup cycle
    if (psel && penable && s.pready && pwrite && !s.pslverr) begin
      unique case (paddr)
        A_CTRL: next_s.ctrl = pwdata[CTRL_W-1:0];
        A_RFEN: next_s.rf_en = pwdata[NCH-1:0];
        A_CLEN: next_s.cl_en = pwdata[NCH-1:0];
        A_DUEN: next_s.du_en = pwdata[NCH-1:0];
        A_YINH: next_s.yinh = pwdata[NCH-1:0];
        default: begin
        end
      endcase
    end
    next_s.pready = psel & ~penable;
    if (psel && !penable) begin
      next_s.pslverr = 1'h0;
      next_s.prdata = '0;
      unique case (paddr)
        A_CTRL: next_s.prdata = 32'(s.ctrl);
        A_RFEN: next_s.prdata = 32'(s.rf_en);
        A_CLEN: next_s.prdata = 32'(s.cl_en);
        A_DUEN: next_s.prdata = 32'(s.du_en);
        A_YINH: next_s.prdata = 32'(s.yinh);
        A_STAT: next_s.prdata = 32'(stat);
        A_FCH: next_s.prdata = 32'(s.fch);
        A_QRED: next_s.prdata = 32'(qr);
        A_QYEL: next_s.prdata = 32'(qy);
        A_QGRN: next_s.prdata = 32'(qg);
        default: next_s.pslverr = 1'h1;
      endcase
      if (pwrite && paddr > A_YINH) begin
        next_s.pslverr = 1'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign cabinet_flash = s.cab_flash;
  assign ac_led = s.ac_led;
  assign prog_led = s.prog_led;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_flash_end;
    s.st == ST_FLASH ##1 s.st == ST_RUN;
  endsequence

  property p_flash_min;
    s_flash_end |-> $past(s.fl_ms) >= FLASH_MIN_MS && $past(s.wd_cnt) == WD_TRANS;
  endproperty
  a_flash_min: assert property (p_flash_min) else $error("flash interval ended early");

  property p_cable;
    mon && !s.m2[I_CABLE] |=> s.f_cable ##1 s.cab_flash;
  endproperty
  a_cable: assert property (p_cable) else $error("cable fault not raised");

  property p_latch;
    s.f_red && !clr |=> s.f_red;
  endproperty
  a_latch: assert property (p_latch) else $error("red fault lost without reset");

  property p_cfg_hold;
    s.f_cfg && s.hold_ms < CFG_HOLD_MS |=> s.f_cfg;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings fault cleared early");

  property p_wdog;
    s.st == ST_FLASH && s.fl_ms == WD_LIMIT_MS && s.wd_cnt != WD_TRANS |=> s.f_wdog;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog fault missed");

  property p_dual_gate;
    !ren && !s.f_dual |=> !s.f_dual;
  endproperty
  a_dual_gate: assert property (p_dual_gate) else $error("dual fault while gated");

  property p_inhibit;
    q_sf != 2'h0 && !s.f_red |=> !s.f_red;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("red fault while inhibited");

  property p_flash_out;
    s.st != ST_RUN |=> s.cab_flash;
  endproperty
  a_flash_out: assert property (p_flash_out) else $error("cabinet not flashing");

endmodule // tsm_monitor

// [hw/tsm_pkg.sv]
// Shared constants and types for the traffic signal fault monitor
package tsm_pkg;

  // ----------------------------------------------------------------
  // Sizes and clock
  // ----------------------------------------------------------------
  localparam int NCH = 18;
  localparam int TW = 14;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // ----------------------------------------------------------------
  // Times in milliseconds, one timer step per tick
  // ----------------------------------------------------------------
  localparam logic [13:0] SF_ON_MS = 14'h0226;
  localparam logic [13:0] FIELD_ON_MS = 14'h01F4;
  localparam logic [13:0] RF1_MS = 14'h0352;
  localparam logic [13:0] RF2_MS = 14'h0546;
  localparam logic [13:0] DUAL_MS = 14'h015E;
  localparam logic [13:0] CLR_MS = 14'h0A8C;
  localparam logic [13:0] RATE_MS = 14'h05DC;
  localparam logic [13:0] CFG_HOLD_MS = 14'h0BB8;
  localparam logic [13:0] FLASH_MIN_MS = 14'h1770;
  localparam logic [13:0] WD_LIMIT_MS = 14'h2710;
  localparam logic [13:0] BLINK_MS = 14'h007D;
  localparam logic [2:0] WD_TRANS = 3'h5;

  // ----------------------------------------------------------------
  // Synchronised input vector layout
  // ----------------------------------------------------------------
  localparam int I_CABLE = 0;
  localparam int I_WD = 1;
  localparam int I_ACOK = 2;
  localparam int I_ACRS = 3;
  localparam int I_FRONT = 4;
  localparam int I_REMOTE = 5;
  localparam int I_RED = 6;
  localparam int I_YEL = 24;
  localparam int I_GRN = 42;
  localparam int I_REN = 60;
  localparam int I_SF = 61;
  localparam int I_RCS = 63;
  localparam int NIN = 64;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_RFEN = 12'h004;
  localparam logic [11:0] A_CLEN = 12'h008;
  localparam logic [11:0] A_DUEN = 12'h00C;
  localparam logic [11:0] A_YINH = 12'h010;
  localparam logic [11:0] A_STAT = 12'h014;
  localparam logic [11:0] A_FCH = 12'h018;
  localparam logic [11:0] A_QRED = 12'h01C;
  localparam logic [11:0] A_QYEL = 12'h020;
  localparam logic [11:0] A_QGRN = 12'h024;
  localparam int CTRL_W = 9;
  localparam int C_TYPE2 = 0;
  localparam int C_FAILSAFE = 1;
  localparam int C_GYDUAL = 2;
  localparam int C_COMPACT = 3;
  localparam int C_RATEDIS = 4;
  localparam int C_PHASE = 5;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [17:0] EN_RST = 18'h00000;
  localparam int S_ANY = 0;
  localparam int S_RED = 1;
  localparam int S_CLR = 2;
  localparam int S_DUAL = 3;
  localparam int S_CFG = 4;
  localparam int S_WDOG = 5;
  localparam int S_CABLE = 6;
  localparam int S_ACDROP = 7;
  localparam int S_RATE = 8;
  localparam int S_FLASH = 9;
  localparam int STAT_W = 10;

  typedef enum logic [1:0] {
    ST_FLASH = 2'b00,
    ST_RUN = 2'b01,
    ST_DROP = 2'b10
  } tsm_state_e;

endpackage

// [hw/tsm_qual.sv]
// Duration qualifier for above-threshold indications
`timescale 1ns/10ps
module tsm_qual #(
  parameter int W = 1,
  parameter logic [13:0] ON_MS = 14'h0001
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] q
);
  import tsm_pkg::*;

  typedef struct packed {
    logic [W-1:0][13:0] cnt;
    logic [W-1:0] q;
  } tsm_qual_s;

  tsm_qual_s s, next_s;
  logic [W-1:0] at_lim;

  // Off at once when the level drops, on only after an unbroken run
  always_comb begin
    next_s = s;
    for (int i = 0; i < W; i++) begin
      at_lim[i] = s.cnt[i] > ON_MS;
      if (!raw[i]) begin
        next_s.cnt[i] = '0;
        next_s.q[i] = 1'h0;
      end else if (at_lim[i]) begin
        next_s.q[i] = 1'h1;
      end else if (tick) begin
        next_s.cnt[i] = s.cnt[i] + 14'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_off;
    1'h1 |=> ((q & ~$past(raw)) == '0);
  endproperty
  a_off: assert property (p_off) else $error("qualified on while input low");

  property p_min;
    1'h1 |=> ((q & ~$past(q) & ~$past(at_lim)) == '0);
  endproperty
  a_min: assert property (p_min) else $error("qualified on before full duration");

endmodule // tsm_qual

// [hw/tsm_tick.sv]
// Millisecond tick generator
`timescale 1ns/10ps
module tsm_tick #(
  parameter int CYC = 20000
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  import tsm_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tsm_tick_s;

  tsm_tick_s s, next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'h0;
    if (s.cnt == 16'(CYC - 1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'h1;
    end else begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn) tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick pulses too close");

endmodule // tsm_tick

// [tb/tb_traffic_signal_fault_monitor.sv]
// Self-checking testbench for the fault supervision core
`timescale 1ns/10ps
module tb_traffic_signal_fault_monitor;
  import tsm_pkg::*;
  // Short tick keeps the 6 s flash interval affordable
  localparam int T = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d;
  logic pready, pslverr, cabinet_flash, ac_led, prog_led, wd;
  logic cable = 1, ac_ok = 1, front = 0, remote = 0;
  logic [1:0] sf = '0;
  logic [NCH-1:0] dark = '0, dual = '0, f_r, f_y, f_g;
  logic [32:0] exp_q[$];
  int err_count = 0, n_tests = 0, cyc = 0, n;

  tsm_monitor #(.TICK_CYCLES(T)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field_red(f_r), .field_yel(f_y), .field_grn(f_g), .red_enable(1'b1), .sf_inhibit(sf),
    .relay_common_sense(1'b0), .red_interface_cable(cable), .watchdog_in(wd), .ac_above_dropout(ac_ok),
    .ac_above_restore(ac_ok), .front_reset(front), .remote_reset(remote), .cabinet_flash(cabinet_flash),
    .ac_led(ac_led), .prog_led(prog_led));
  tsm_field_model i_field (.pclk(pclk), .dark(dark), .dual(dual), .field_red(f_r), .field_yel(f_y),
    .field_grn(f_g), .watchdog_in(wd));

  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic flag(input logic g, input logic e);
    chk({32'h0, g}, {32'h0, e});
  endtask

  // ------------------------------------------------------------
  // Bus master and helpers
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ms(input int m);
    repeat (m * T) @(posedge pclk);
  endtask

  task automatic waitf(output int c);
    c = 0;
    while (cabinet_flash !== 1'b1 && c < 2000 * T) begin
      @(posedge pclk);
      c++;
    end
  endtask

  // Edges of the power lamp over one second
  task automatic togs(output int c);
    logic p;
    c = 0;
    p = ac_led;
    repeat (1000 * T) begin
      @(posedge pclk);
      if (ac_led !== p) c++;
      p = ac_led;
    end
  endtask

  task automatic btn(input logic rem, input int m);
    if (rem) remote <= 1'b1;
    else front <= 1'b1;
    ms(m);
    remote <= 1'b0;
    front <= 1'b0;
    ms(5);
  endtask

  // Read results are judged in arrival order
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'h9b43de37));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_CTRL, 0, 33'h0);
    apb(0, 12'h030, 0, {1'b1, 32'h0});
    apb(1, A_STAT, 32'hFFFFFFFF, 33'h0);
    apb(0, A_STAT, 0, 33'h200);
    // Channel 2 must not be yellow-inhibited for the clearance check
    d = $urandom & 32'hFFFFFFFD;
    apb(1, A_YINH, d, 33'h0);
    apb(0, A_YINH, 0, {15'h0, d[17:0]});
    apb(1, A_RFEN, 32'h1, 33'h0);
    apb(1, A_DUEN, 32'h2, 33'h0);
    apb(1, A_CLEN, 32'h2, 33'h0);
    togs(n);
    flag(n >= 7 && n <= 9, 1'b1);
    flag(cabinet_flash, 1'b1);
    while (cabinet_flash !== 1'b0 && cyc < 11000 * T) @(posedge pclk);
    flag(cyc >= 6000 * T && cyc < 6100 * T, 1'b1);
    ms(10);
    flag(ac_led, 1'b1);
    apb(0, A_STAT, 0, 33'h0);
    dark <= 18'h00001;
    waitf(n);
    flag(n > 700 * T && n <= 1000 * T, 1'b1);
    apb(0, A_STAT, 0, 33'h3);
    apb(0, A_FCH, 0, 33'h1);
    dark <= '0;
    ms(100);
    btn(1, 5);
    apb(0, A_STAT, 0, 33'h3);
    ms(600);
    btn(1, 5);
    apb(0, A_STAT, 0, 33'h0);
    flag(cabinet_flash, 1'b0);
    dual <= 18'h00002;
    waitf(n);
    flag(n > 500 * T && n <= 1050 * T, 1'b1);
    apb(0, A_STAT, 0, 33'h9);
    dual <= '0;
    ms(5);
    apb(0, A_STAT, 0, 33'hD);
    btn(0, 5);
    apb(0, A_STAT, 0, 33'h0);
    sf <= 2'b10;
    ms(600);
    dark <= 18'h00001;
    ms(1100);
    apb(0, A_STAT, 0, 33'h0);
    dark <= '0;
    ms(600);
    sf <= 2'b00;
    apb(1, A_CTRL, 32'h4, 33'h0);
    ms(5);
    apb(0, A_STAT, 0, 33'h11);
    btn(1, 5);
    apb(0, A_STAT, 0, 33'h11);
    btn(0, 3100);
    apb(0, A_STAT, 0, 33'h0);
    cable <= 1'b0;
    waitf(n);
    flag(n <= 20 * T, 1'b1);
    apb(0, A_STAT, 0, 33'h41);
    cable <= 1'b1;
    btn(1, 5);
    apb(0, A_STAT, 0, 33'h0);
    ac_ok <= 1'b0;
    ms(10);
    flag(cabinet_flash, 1'b1);
    togs(n);
    flag(n >= 3 && n <= 5, 1'b1);
    ac_ok <= 1'b1;
    ms(100);
    flag(cabinet_flash, 1'b1);
    end_of_test();
  end
endmodule // tb_traffic_signal_fault_monitor

// [tb/tsm_field_model.sv]
// Controller and field signal model driving the monitor's field inputs
`timescale 1ns/10ps
module tsm_field_model (
  input wire logic pclk,
  input wire logic [tsm_pkg::NCH-1:0] dark,
  input wire logic [tsm_pkg::NCH-1:0] dual,
  output logic [tsm_pkg::NCH-1:0] field_red,
  output logic [tsm_pkg::NCH-1:0] field_yel,
  output logic [tsm_pkg::NCH-1:0] field_grn,
  output logic watchdog_in
);
  int cnt = 0;
  logic wd_q = 1'b0;
  assign watchdog_in = wd_q;
  // ------------------------------------------------------------
  // Reds rest on; dark drops every lamp, dual adds a green
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    field_red <= ~dark;
    field_yel <= '0;
    field_grn <= dual & ~dark;
    cnt <= (cnt == 399) ? 0 : cnt + 1;
    if (cnt == 399) begin
      wd_q <= ~wd_q;
    end
  end
endmodule // tsm_field_model
